// *** rtl/psb_mode_ctrl.sv ***
// Mode control, protection sequencing and gate timing of the bridge controller.

// Behaviour
// [R1] Slope strap to ground selects current mode.
// [R2] Slope strap to reference selects voltage mode.
// [R3] Modes and sync roles are mutually exclusive.
// [R4] Light load: discontinuous mode, rectifiers off.
// [R5] Demand below minimum width enters burst.
// [R6] Bursts always hold an even pulse count.
// [R7] Leader is default, timing strap to reference.
// [R8] Follower runs ninety degrees behind leader.
// [R9] Board straps select follower operation.
// [R10] Follower takes sync pin as input, locks.
// [R11] Current limit truncates the present pulse.
// [R12] Hiccup stops switching after limit dwell.
// [R13] Restart via soft start after delay.
// [R14] Latch strap latches off on limit.
// [R15] Rectifier gates overlap during freewheel.
// [R16] Rectifier turn-off moves with load.
// [R17] Leg dead time varies with load.
// [R18] Enforce programmed minimum on-time.
// [R19] Low load drives rectifier gates low.
// [R20] Normal, then discontinuous, then burst.
// [R21] Leader emits sync at double rate, half duty.
// [R22] Follower aligns to falling sync edge.
// [R23] Follower free-runs when sync pulses stop.
// [R24] Leader sync starts only once enabled.
// [R25] Skip intervals hold all gates low.
module psb_mode_ctrl #(
  parameter int          CNT_W         = psb_pkg::CNT_W,
  parameter int unsigned CL_ON_CYCLES  = psb_pkg::CL_ON_CYC,
  parameter int unsigned CL_OFF_CYCLES = psb_pkg::CL_OFF_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             slope_comp_pin,
  input  wire logic             freq_resistor_pin,
  input  wire logic             ss_follower_strap,
  input  wire logic             ss_latch_strap,
  input  wire logic             ss_enable,
  input  wire logic             cs_limit,
  input  wire logic             cs_peak,
  input  wire logic             light_load_threshold_pin,
  input  wire logic             sync_in,
  input  wire logic [CNT_W-1:0] demand_width,
  input  wire logic [CNT_W-1:0] min_on_width_pin,
  input  wire logic [2:0]       load_level,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  output logic                  lead_leg_gate_one,
  output logic                  lead_leg_gate_two,
  output logic                  lag_leg_gate_one,
  output logic                  lag_leg_gate_two,
  output logic                  rectifier_gate_one,
  output logic                  rectifier_gate_two,
  output logic                  sync_out,
  output logic                  sync_oe_n,
  output logic                  current_mode,
  output logic                  voltage_mode,
  output logic                  leader_mode,
  output logic                  follower_mode
);

  logic [psb_pkg::PIN_W-1:0] pins_s;
  logic                      ss_en_s;
  logic                      cs_lim_s;
  logic                      sync_d_reg;
  logic                      sync_fall;
  logic [1:0]                settle_reg;
  logic                      strap_done_reg;
  logic                      latch_cfg_reg;
  logic                      got_sync_reg;
  logic                      sw_en_reg;
  logic [CNT_W-1:0]          half_len_reg;
  logic [CNT_W-1:0]          cnt_reg;
  logic                      half_reg;
  logic [CNT_W-1:0]          edge_reg;
  logic [CNT_W-1:0]          ss_cap_reg;
  logic                      fire_reg;
  logic                      lim_seen_reg;
  psb_pkg::psb_state_t       state_reg;
  psb_pkg::psb_light_t       light_reg;
  logic                      osc_run;
  logic                      half_end;
  logic                      cycle_end;
  logic                      switching;
  logic                      burst_req;
  logic                      burst_skip;
  logic [CNT_W-1:0]          width_sel;
  logic [3:0]                dead_t;
  logic [3:0]                sr_adv;
  logic                      pwr;
  logic                      after_dead;
  logic                      lag_free;
  logic                      sr_hold;
  logic                      on_done;
  logic                      off_done;
  logic                      enter_limit;
  logic                      enter_hiccup;

  psb_sync2 #(.W(psb_pkg::PIN_W)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({sync_in, light_load_threshold_pin, cs_peak, cs_limit, ss_enable,
                ss_latch_strap, ss_follower_strap, freq_resistor_pin, slope_comp_pin}),
    .pin_sync (pins_s)
  );

  assign ss_en_s  = pins_s[psb_pkg::PIN_SSEN];
  assign cs_lim_s = pins_s[psb_pkg::PIN_CSLIM];
  assign sync_fall = sync_d_reg && !pins_s[psb_pkg::PIN_SYNC];

  // Straps are sampled once the synchroniser has settled after reset; until then the
  // mode outputs report a current-mode leader, with the oscillator and sync pin idle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
      current_mode   <= 1'b1;
      voltage_mode   <= 1'b0;
      leader_mode    <= 1'b1;
      follower_mode  <= 1'b0;
      latch_cfg_reg  <= 1'b0;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == psb_pkg::STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        current_mode   <= !pins_s[psb_pkg::PIN_SLOPE]; // [R1]
        voltage_mode   <= pins_s[psb_pkg::PIN_SLOPE];  // [R2]
        follower_mode  <= !pins_s[psb_pkg::PIN_RT] && pins_s[psb_pkg::PIN_SSF]; // [R9]
        leader_mode    <= !(!pins_s[psb_pkg::PIN_RT] && pins_s[psb_pkg::PIN_SSF]); // [R7]
        latch_cfg_reg  <= pins_s[psb_pkg::PIN_LATCH];
      end
    end
  end

  // Register port: control and half-period are writable, status reflects the block.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_en_reg    <= psb_pkg::CTRL_EN_RST;
      half_len_reg <= CNT_W'(psb_pkg::HALF_LEN_RST);
    end else if (reg_wr) begin
      if (reg_addr == psb_pkg::ADDR_CTRL) begin
        sw_en_reg <= reg_wdata[psb_pkg::CTRL_EN_BIT];
      end
      if (reg_addr == psb_pkg::ADDR_HALF) begin
        half_len_reg <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      case (reg_addr)
        psb_pkg::ADDR_CTRL:   reg_rdata <= {31'h0, sw_en_reg};
        psb_pkg::ADDR_HALF:   reg_rdata <= 32'(half_len_reg);
        psb_pkg::ADDR_STATUS: reg_rdata <= {19'h0, got_sync_reg, voltage_mode, current_mode,
                                            follower_mode, leader_mode, 2'h0, light_reg,
                                            1'b0, state_reg};
        default:              reg_rdata <= 32'h0;
      endcase
    end
  end

  // A follower holds its oscillator until the first sync pulse, then keeps running on
  // its own period even if the pulses stop.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_d_reg   <= 1'b0;
      got_sync_reg <= 1'b0;
    end else begin
      sync_d_reg <= pins_s[psb_pkg::PIN_SYNC];
      if (follower_mode && sync_fall) begin
        got_sync_reg <= 1'b1; // [R23]
      end
    end
  end

  assign osc_run   = strap_done_reg && (leader_mode || got_sync_reg);
  assign half_end  = (cnt_reg == half_len_reg - CNT_W'(1));
  assign cycle_end = half_end && half_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      half_reg <= 1'b0;
    end else if (follower_mode && sync_in_fall_ok()) begin
      cnt_reg  <= '0; // [R8] [R10] [R22]
      half_reg <= !half_reg;
    end else if (osc_run) begin
      cnt_reg  <= half_end ? '0 : cnt_reg + CNT_W'(1);
      half_reg <= half_end ? !half_reg : half_reg;
    end
  end

  function automatic logic sync_in_fall_ok();
    return sync_fall;
  endfunction : sync_in_fall_ok

  // Light-load ladder: normal, then diode rectification, then burst.
  assign burst_req  = (demand_width < min_on_width_pin); // [R5]
  assign burst_skip = (demand_width < (min_on_width_pin >> 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      light_reg <= psb_pkg::LM_NORMAL;
    end else if (pins_s[psb_pkg::PIN_LIGHT] && burst_req) begin
      light_reg <= psb_pkg::LM_BURST; // [R20]
    end else if (pins_s[psb_pkg::PIN_LIGHT]) begin
      light_reg <= psb_pkg::LM_DCM; // [R4] [R20]
    end else begin
      light_reg <= psb_pkg::LM_NORMAL;
    end
  end

  always_comb begin
    width_sel = burst_req ? min_on_width_pin : demand_width; // [R18]
    if (state_reg == psb_pkg::ST_SOFT && ss_cap_reg < width_sel) begin
      width_sel = ss_cap_reg;
    end
  end

  assign dead_t = psb_pkg::DT_BASE + {1'b0, ~load_level};     // [R17]
  assign sr_adv = psb_pkg::SR_ADV_BASE + {1'b0, load_level};  // [R16]
  assign switching = (state_reg == psb_pkg::ST_SOFT) || (state_reg == psb_pkg::ST_RUN) ||
                     (state_reg == psb_pkg::ST_LIMIT);

  // Skip decisions are taken only at a whole-cycle boundary, so every burst is made of
  // complete cycles of two pulses each.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fire_reg <= 1'b0;
      edge_reg <= '0;
    end else begin
      if (!switching) begin
        fire_reg <= 1'b0; // [R12]
      end else if (cycle_end) begin
        fire_reg <= !(light_reg == psb_pkg::LM_BURST && burst_skip); // [R6] [R25]
      end
      if (half_end) begin
        edge_reg <= width_sel;
      end else if (pwr && (cs_lim_s ||
                   (current_mode && pins_s[psb_pkg::PIN_CSPK] && cnt_reg >= min_on_width_pin))) begin
        edge_reg <= cnt_reg; // [R11] [R18]
      end
    end
  end

  assign pwr        = fire_reg && (cnt_reg < edge_reg);
  assign after_dead = ({1'b0, cnt_reg} >= (CNT_W+1)'(dead_t));
  assign lag_free   = ({1'b0, cnt_reg} >= {1'b0, edge_reg} + (CNT_W+1)'(dead_t));
  assign sr_hold    = ({1'b0, cnt_reg} + (CNT_W+1)'(sr_adv) < {1'b0, half_len_reg});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lead_leg_gate_one  <= 1'b0;
      lead_leg_gate_two  <= 1'b0;
      lag_leg_gate_one   <= 1'b0;
      lag_leg_gate_two   <= 1'b0;
      rectifier_gate_one <= 1'b0;
      rectifier_gate_two <= 1'b0;
    end else begin
      lead_leg_gate_one  <= fire_reg && !half_reg && after_dead; // [R17]
      lead_leg_gate_two  <= fire_reg && half_reg && after_dead;
      lag_leg_gate_one   <= fire_reg && ((!half_reg && lag_free) || (half_reg && pwr));
      lag_leg_gate_two   <= fire_reg && ((half_reg && lag_free) || (!half_reg && pwr));
      // Rectifiers overlap while the windings freewheel and open early with load.
      rectifier_gate_one <= fire_reg && (light_reg == psb_pkg::LM_NORMAL) &&
                            ((!half_reg && sr_hold) || (half_reg && !pwr)); // [R15] [R19]
      rectifier_gate_two <= fire_reg && (light_reg == psb_pkg::LM_NORMAL) &&
                            ((half_reg && sr_hold) || (!half_reg && !pwr)); // [R15] [R16]
    end
  end

  // Sync output: high for the first half of each half-cycle gives twice the switching
  // rate at half duty. The pin is only driven by a leader.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_out  <= 1'b0;
      sync_oe_n <= 1'b1;
    end else begin
      // Stay off the shared pin until the straps are known, so a follower never fights the leader.
      sync_oe_n <= !(strap_done_reg && leader_mode); // [R10]
      sync_out  <= leader_mode && ss_en_s && osc_run &&
                   (cnt_reg < (half_len_reg >> 1)); // [R21] [R24]
    end
  end

  // Protection and start-up sequencing.
  assign enter_limit  = cs_lim_s && (state_reg == psb_pkg::ST_SOFT ||
                                     state_reg == psb_pkg::ST_RUN) && !latch_cfg_reg;
  assign enter_hiccup = (state_reg == psb_pkg::ST_LIMIT) && on_done;

  psb_dwell_timer #(.W(32)) u_on_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (enter_limit),
    .load_val (32'(CL_ON_CYCLES)),
    .run      (state_reg == psb_pkg::ST_LIMIT),
    .done     (on_done)
  );

  psb_dwell_timer #(.W(32)) u_off_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (enter_hiccup),
    .load_val (32'(CL_OFF_CYCLES)),
    .run      (state_reg == psb_pkg::ST_HICCUP),
    .done     (off_done)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lim_seen_reg <= 1'b0;
    end else if (cs_lim_s) begin
      lim_seen_reg <= 1'b1;
    end else if (cycle_end) begin
      lim_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg  <= psb_pkg::ST_OFF;
      ss_cap_reg <= '0;
    end else if (!ss_en_s || !sw_en_reg) begin
      state_reg  <= psb_pkg::ST_OFF;
      ss_cap_reg <= '0;
    end else begin
      case (state_reg)
        psb_pkg::ST_OFF: begin
          if (osc_run) begin
            state_reg <= psb_pkg::ST_SOFT;
          end
        end
        psb_pkg::ST_SOFT: begin
          if (cs_lim_s && latch_cfg_reg) begin
            state_reg <= psb_pkg::ST_LATCHED; // [R14]
          end else if (enter_limit) begin
            state_reg <= psb_pkg::ST_LIMIT;
          end else if (ss_cap_reg >= half_len_reg) begin
            state_reg <= psb_pkg::ST_RUN;
          end else if (cycle_end) begin
            ss_cap_reg <= ss_cap_reg + CNT_W'(1);
          end
        end
        psb_pkg::ST_RUN: begin
          if (cs_lim_s && latch_cfg_reg) begin
            state_reg <= psb_pkg::ST_LATCHED; // [R14]
          end else if (enter_limit) begin
            state_reg <= psb_pkg::ST_LIMIT;
          end
        end
        psb_pkg::ST_LIMIT: begin
          if (enter_hiccup) begin
            state_reg <= psb_pkg::ST_HICCUP; // [R12]
          end else if (cycle_end && !lim_seen_reg && !cs_lim_s) begin
            state_reg <= psb_pkg::ST_RUN;
          end
        end
        psb_pkg::ST_HICCUP: begin
          if (off_done) begin
            state_reg  <= psb_pkg::ST_SOFT; // [R13]
            ss_cap_reg <= '0;
          end
        end
        psb_pkg::ST_LATCHED: state_reg <= psb_pkg::ST_LATCHED;
        default:             state_reg <= psb_pkg::ST_OFF;
      endcase
    end
  end

  // Helper for the burst check: parity of lead-leg pulses since switching began.
  logic pulse_par_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_par_reg <= 1'b0;
    end else if (!switching) begin
      pulse_par_reg <= 1'b0;
    end else if ((lead_leg_gate_one && !$past(lead_leg_gate_one)) ||
                 (lead_leg_gate_two && !$past(lead_leg_gate_two))) begin
      pulse_par_reg <= !pulse_par_reg;
    end
  end

  sequence hiccup_to_soft_s;
    (state_reg == psb_pkg::ST_HICCUP) ##1 (state_reg == psb_pkg::ST_SOFT);
  endsequence

  sequence limit_hit_s;
    cs_lim_s && pwr && (cnt_reg + CNT_W'(3) < half_len_reg);
  endsequence

  mode_excl_a: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    !(current_mode && voltage_mode) && (leader_mode != follower_mode))
    else $error("mode or role exclusivity broken");

  dcm_sr_off_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    (light_reg != psb_pkg::LM_NORMAL) |=> !rectifier_gate_one && !rectifier_gate_two)
    else $error("rectifier gate on in light-load mode");

  burst_even_a: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    $rose(lead_leg_gate_one) |-> !pulse_par_reg)
    else $error("burst started after odd pulse count");

  follow_quiet_a: assert property (@(posedge core_clk) disable iff (rst) // [R21]
    follower_mode |-> !sync_out && sync_oe_n)
    else $error("follower drives sync pin");

  sync_enable_a: assert property (@(posedge core_clk) disable iff (rst) // [R24]
    !ss_en_s |=> !sync_out)
    else $error("sync pulse while disabled");

  limit_trunc_a: assert property (@(posedge core_clk) disable iff (rst) // [R11]
    limit_hit_s |-> ##2 !(lead_leg_gate_one && lag_leg_gate_two) &&
                        !(lead_leg_gate_two && lag_leg_gate_one))
    else $error("pulse not truncated by current limit");

  latch_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [R14]
    (state_reg == psb_pkg::ST_LATCHED) && ss_en_s && sw_en_reg
      |=> (state_reg == psb_pkg::ST_LATCHED))
    else $error("latched state left while enabled");

  hiccup_quiet_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    (state_reg == psb_pkg::ST_HICCUP) [*3] |-> !lead_leg_gate_one && !lead_leg_gate_two &&
      !lag_leg_gate_one && !lag_leg_gate_two)
    else $error("switching during hiccup off time");

  restart_soft_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    hiccup_to_soft_s |-> (ss_cap_reg == '0))
    else $error("restart without fresh soft start");

  skip_low_a: assert property (@(posedge core_clk) disable iff (rst) // [R25]
    !fire_reg |=> !lead_leg_gate_one && !lead_leg_gate_two && !lag_leg_gate_one &&
      !lag_leg_gate_two && !rectifier_gate_one && !rectifier_gate_two)
    else $error("gate active during skip");

  leg_dead_a: assert property (@(posedge core_clk) disable iff (rst) // [R17]
    !(lead_leg_gate_one && lead_leg_gate_two) && !(lag_leg_gate_one && lag_leg_gate_two))
    else $error("leg shoot-through");

endmodule : psb_mode_ctrl

// *** rtl/psb_pkg.sv ***
// Shared constants and types for the phase-shifted bridge mode controller.
package psb_pkg;

  localparam int CNT_W = 8;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_HALF   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam int CTRL_EN_BIT    = 0;
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_LIGHT_LSB   = 4;
  localparam int ST_LEADER_BIT  = 8;
  localparam int ST_FOLLOW_BIT  = 9;
  localparam int ST_CURRENT_BIT = 10;
  localparam int ST_VOLTAGE_BIT = 11;
  localparam int ST_SYNCED_BIT  = 12;

  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam logic [7:0] HALF_LEN_RST = 8'h7d;

  localparam logic [3:0] DT_BASE     = 4'h2;
  localparam logic [3:0] SR_ADV_BASE = 4'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Pin vector positions at the synchroniser.
  localparam int PIN_SLOPE  = 0;
  localparam int PIN_RT     = 1;
  localparam int PIN_SSF    = 2;
  localparam int PIN_LATCH  = 3;
  localparam int PIN_SSEN   = 4;
  localparam int PIN_CSLIM  = 5;
  localparam int PIN_CSPK   = 6;
  localparam int PIN_LIGHT  = 7;
  localparam int PIN_SYNC   = 8;
  localparam int PIN_W      = 9;

  localparam int          CLK_MHZ    = 25;
  localparam int unsigned CL_ON_US   = 5000;
  localparam int unsigned CL_OFF_US  = 122000;
  localparam int unsigned CL_ON_CYC  = CL_ON_US * CLK_MHZ;
  localparam int unsigned CL_OFF_CYC = CL_OFF_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b010,
    ST_LIMIT   = 3'b011,
    ST_HICCUP  = 3'b100,
    ST_LATCHED = 3'b101
  } psb_state_t;

  typedef enum logic [1:0] {
    LM_NORMAL = 2'b00,
    LM_DCM    = 2'b01,
    LM_BURST  = 2'b10
  } psb_light_t;

endpackage : psb_pkg

// *** rtl/psb_sync2.sv ***
// Two-flop synchroniser for a vector of independent pin levels.
module psb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule : psb_sync2

// *** rtl/psb_dwell_timer.sv ***
// Loadable down-counter that reports when a programmed dwell has elapsed.
module psb_dwell_timer #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  output logic              done
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (run && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done = (cnt_reg == '0) && !load;

endmodule : psb_dwell_timer

// *** testbench/psb_power_stage.sv ***
// Behavioural power stage and current sense seen from the gate outputs.
module psb_power_stage (
  input  wire logic core_clk,
  input  wire logic g_a,
  input  wire logic g_b,
  input  wire logic overload,
  input  wire logic light,
  output logic      cs_limit,
  output logic      cs_peak,
  output logic      light_load_threshold_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] on_cnt = 4'h0;
  // Sense current ramps only while a leading gate conducts, so peak needs eight clocks of drive.
  always @(posedge core_clk) begin
    on_cnt <= (g_a | g_b) ? ((on_cnt == 4'hf) ? on_cnt : on_cnt + 4'h1) : 4'h0;
  end
  assign cs_peak                  = on_cnt >= 4'h8;
  assign cs_limit                 = overload & (g_a | g_b);
  assign light_load_threshold_pin = light;
endmodule : psb_power_stage

// *** testbench/psb_mode_ctrl_bench.sv ***
// Self-checking bench of the bridge mode controller.
module psb_mode_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, slope_comp_pin = 1'b0, freq_resistor_pin = 1'b1;
  logic ss_follower_strap = 1'b0, ss_latch_strap = 1'b0, ss_enable = 1'b0, sync_in = 1'b1;
  logic over = 1'b0, light = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cs_limit, cs_peak, light_load_threshold_pin, sync_out, sync_oe_n;
  logic [7:0]  demand_width = 8'h06, min_on_width_pin = 8'h04, reg_addr = 8'h00;
  logic [2:0]  load_level = 3'h4;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic lead_leg_gate_one, lead_leg_gate_two, lag_leg_gate_one, lag_leg_gate_two;
  logic rectifier_gate_one, rectifier_gate_two, current_mode, voltage_mode;
  logic leader_mode, follower_mode;
  int err_count = 0, checks_done = 0;
  int n_rect, n_ovl, n_lead, n_gate, n_ra, n_rb, n_sync, n_on;
  psb_mode_ctrl #(.CL_ON_CYCLES(50), .CL_OFF_CYCLES(100)) i_psb_mode_ctrl (.core_clk, .rst,
    .slope_comp_pin, .freq_resistor_pin, .ss_follower_strap, .ss_latch_strap, .ss_enable,
    .cs_limit, .cs_peak, .light_load_threshold_pin, .sync_in, .demand_width,
    .min_on_width_pin, .load_level, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lead_leg_gate_one, .lead_leg_gate_two, .lag_leg_gate_one, .lag_leg_gate_two,
    .rectifier_gate_one, .rectifier_gate_two, .sync_out, .sync_oe_n, .current_mode,
    .voltage_mode, .leader_mode, .follower_mode);
  psb_power_stage i_psb_power_stage (.core_clk, .g_a(lead_leg_gate_one),
    .g_b(lead_leg_gate_two), .overload(over), .light, .cs_limit, .cs_peak,
    .light_load_threshold_pin);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Straps only count at reset release, so every configuration starts with a fresh reset.
  task automatic boot(input logic s, input logic r, input logic f, input logic l);
    ss_enable         <= 1'b0;
    over              <= 1'b0;
    rst               <= 1'b1;
    slope_comp_pin    <= s;
    freq_resistor_pin <= r;
    ss_follower_strap <= f;
    ss_latch_strap    <= l;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    wr(psb_pkg::ADDR_HALF, 32'h10);
  endtask : boot
  task automatic ws(input logic [2:0] s);
    int i;
    i = 0;
    rd(psb_pkg::ADDR_STATUS, d);
    while (d[2:0] !== s && i < 600) begin
      rd(psb_pkg::ADDR_STATUS, d);
      i++;
    end
    chk("state", {29'h0, s}, {29'h0, d[2:0]});
  endtask : ws
  task automatic watch(input int n);
    logic pa;
    logic pb;
    pa     = lead_leg_gate_one;
    pb     = lead_leg_gate_two;
    n_rect = 0;
    n_ovl  = 0;
    n_lead = 0;
    n_gate = 0;
    n_ra   = 0;
    n_rb   = 0;
    n_sync = 0;
    n_on   = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      n_rect += int'(rectifier_gate_one | rectifier_gate_two);
      n_ovl  += int'(rectifier_gate_one & rectifier_gate_two);
      n_lead += int'(lead_leg_gate_one & lead_leg_gate_two);
      n_gate += int'(lead_leg_gate_one | lead_leg_gate_two | lag_leg_gate_one | lag_leg_gate_two
                     | rectifier_gate_one | rectifier_gate_two);
      n_ra   += int'(lead_leg_gate_one && !pa);
      n_rb   += int'(lead_leg_gate_two && !pb);
      n_on   += int'(lead_leg_gate_one | lead_leg_gate_two);
      n_sync += int'(sync_out === 1'b1);
      pa     = lead_leg_gate_one;
      pb     = lead_leg_gate_two;
    end
  endtask : watch
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #(40 * 60000);
    err_count++;
    report_and_stop();
  end
  initial begin
    boot(1'b1, 1'b1, 1'b0, 1'b0);
    chk("voltage", 1, voltage_mode);
    chk("current", 0, current_mode);
    boot(1'b0, 1'b1, 1'b0, 1'b0);
    chk("current", 1, current_mode);
    chk("leader", 2'b10, {leader_mode, follower_mode});
    rd(psb_pkg::ADDR_CTRL, d);
    chk("ctrl", 1, d);
    rd(8'h0c, d);
    chk("unmapped", 0, d);
    watch(100);
    chk("sync before enable", 0, n_sync);
    ss_enable <= 1'b1;
    ws(3'h2);
    watch(64);
    chk("sync high clocks", 32, n_sync);
    chk("sync drive", 0, sync_oe_n);
    chk("lead overlap", 0, n_lead);
    chk("rect overlap", 1, n_ovl > 0);
    chk("lead on load4", 64 - 4 * (psb_pkg::DT_BASE + 3), n_on);
    load_level <= 3'h0;
    repeat (4) @(posedge core_clk);
    watch(64);
    chk("lead on load0", 64 - 4 * (psb_pkg::DT_BASE + 7), n_on);
    load_level <= 3'h4;
    light <= 1'b1;
    repeat (20) @(posedge core_clk);
    watch(100);
    chk("rect light", 0, n_rect);
    rd(psb_pkg::ADDR_STATUS, d);
    chk("light mode", 1, d[5:4]);
    demand_width <= 8'h03;
    @(posedge lead_leg_gate_one);
    watch(320);
    rd(psb_pkg::ADDR_STATUS, d);
    chk("burst mode", 2, d[5:4]);
    chk("burst pulses", n_ra, n_rb);
    demand_width <= 8'h01;
    repeat (80) @(posedge core_clk);
    watch(100);
    chk("skip gates", 0, n_gate);
    demand_width <= 8'hff;
    light        <= 1'b0;
    over         <= 1'b1;
    ws(3'h3);
    ws(3'h4);
    watch(20);
    chk("hiccup gates", 0, n_gate);
    over <= 1'b0;
    ws(3'h1);
    boot(1'b0, 1'b1, 1'b0, 1'b1);
    ss_enable <= 1'b1;
    over      <= 1'b1;
    ws(3'h5);
    boot(1'b0, 1'b0, 1'b1, 1'b0);
    chk("follower", 3'b011, {leader_mode, follower_mode, sync_oe_n});
    ss_enable <= 1'b1;
    watch(100);
    chk("no sync no gates", 0, n_gate);
    repeat (8) begin
      repeat (8) @(posedge core_clk);
      sync_in <= 1'b0;
      repeat (8) @(posedge core_clk);
      sync_in <= 1'b1;
    end
    rd(psb_pkg::ADDR_STATUS, d);
    chk("synced", 1, d[psb_pkg::ST_SYNCED_BIT]);
    ws(3'h2);
    watch(200);
    chk("free run", 1, n_ra > 0);
    report_and_stop();
  end
endmodule : psb_mode_ctrl_bench
